// File: verilog/rtcc_cfg.svh
`ifndef RTCC_CFG_SVH
`define RTCC_CFG_SVH

// ============================================================
// register offsets
`define RTCC_OFS_SEC    4'h0
`define RTCC_OFS_MIN    4'h1
`define RTCC_OFS_HOUR   4'h2
`define RTCC_OFS_WDAY   4'h3
`define RTCC_OFS_MDAY   4'h4
`define RTCC_OFS_MONTH  4'h5
`define RTCC_OFS_YEAR   4'h6
`define RTCC_OFS_CTRL2  4'hf

// ============================================================
// writable field masks, other bits read zero
`define RTCC_MSK_SEC    8'h7f
`define RTCC_MSK_MIN    8'h7f
`define RTCC_MSK_HOUR   8'h3f
`define RTCC_MSK_WDAY   8'h07
`define RTCC_MSK_MDAY   8'h3f
`define RTCC_MSK_MONTH  8'h9f
`define RTCC_MSK_YEAR   8'hff

// ============================================================
// control register 2 bit positions
`define RTCC_B_PWRON    4
`define RTCC_B_PFLAG    2
`define RTCC_B_WFLAG    1
`define RTCC_B_DFLAG    0

// ============================================================
// counter limits and reset values
`define RTCC_BCD_59     8'h59
`define RTCC_BCD_23     8'h23
`define RTCC_BCD_12     8'h12
`define RTCC_BCD_11     8'h11
`define RTCC_BCD_99     8'h99
`define RTCC_BCD_01     8'h01
`define RTCC_BCD_00     8'h00
`define RTCC_WDAY_LAST  3'h6
`define RTCC_PM_BIT     5
`define RTCC_CENT_BIT   7

// ============================================================
// timing
`define RTCC_CLK_NS        10
`define RTCC_ALARM_DLY_NS  31000
`define RTCC_ALARM_DLY_CYC \
  ((`RTCC_ALARM_DLY_NS + `RTCC_CLK_NS - 1) / `RTCC_CLK_NS)
`define RTCC_OSC_PER_SEC   32768

`endif

// File: verilog/rtcc_pkg.sv
package rtcc_pkg;

  // ============================================================
  // time and calendar counters as one carrier
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [2:0] wday;
    logic [7:0] mday;
    logic       century;
    logic [7:0] month;
    logic [7:0] year;
  } rtcc_time_t;

  // ============================================================
  // periodic interrupt output modes
  typedef enum logic [2:0] {
    RTCC_PS_OFF,
    RTCC_PS_LOW,
    RTCC_PS_2HZ,
    RTCC_PS_1HZ,
    RTCC_PS_SEC,
    RTCC_PS_MIN,
    RTCC_PS_HOUR,
    RTCC_PS_MONTH
  } rtcc_psel_t;

  // ============================================================
  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtcc_req_t;

endpackage

// File: verilog/rtcc_bcd_step.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// one bcd counter step with wrap from hi to lo
module rtcc_bcd_step (
  input  wire logic [7:0] cur,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  output logic      [7:0] nxt,
  output logic            wrap
);

  always_comb begin
    wrap = (cur == hi);
    if (wrap) begin
      nxt = lo;
    end else if (cur[3:0] == 4'h9) begin
      nxt = {cur[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = {cur[7:4], cur[3:0] + 4'h1};
    end
  end

endmodule // rtcc_bcd_step

`default_nettype wire

// File: verilog/rtcc_core.sv
`include "rtcc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rtcc_core #(
  parameter int OSC_PER_SEC = `RTCC_OSC_PER_SEC
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 osc_clk,
  input  wire rtcc_pkg::rtcc_req_t  req,
  output logic               [7:0]  rdata,
  input  wire logic          [2:0]  periodic_select,
  input  wire logic                 mode_24h,
  input  wire logic                 weekly_alarm_enable,
  input  wire logic                 daily_alarm_enable,
  input  wire logic                 weekly_alarm_match,
  input  wire logic                 daily_alarm_match,
  input  wire logic                 power_on_flag,
  output logic                      irq_out_n
);
  import rtcc_pkg::*;
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  localparam int DIV_W = $clog2(OSC_PER_SEC);
  localparam int DLY_W = 13;
  localparam logic [DLY_W-1:0] ALARM_DLY = DLY_W'(`RTCC_ALARM_DLY_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_PER_SEC - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(OSC_PER_SEC / 2);
  localparam logic [DIV_W-1:0] DIV_QTR  = DIV_W'(OSC_PER_SEC / 4);

  // ============================================================
  // helpers
  function automatic logic is_leap(input logic [7:0] y);
    // tens*10 mod 4 is 2 when tens is odd
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] mo,
                                          input logic [7:0] y);
    if (mo == 8'h02) begin
      last_day = is_leap(y) ? 8'h29 : 8'h28;
    end else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 ||
                 mo == 8'h11) begin
      last_day = 8'h30;
    end else begin
      last_day = 8'h31;
    end
  endfunction

  function automatic logic wr_at(input rtcc_req_t r, input logic [3:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction

  // ============================================================
  // oscillator sampling and sub-second divider
  logic             osc_s1_q;
  logic             osc_s2_q;
  logic             osc_prev_q;
  logic [DIV_W-1:0] div_q;
  logic             osc_rise;
  logic             sec_tick;
  logic             sec_wr;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_q   <= 1'b0;
      osc_s2_q   <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_s1_q   <= osc_clk;
      osc_s2_q   <= osc_s1_q;
      osc_prev_q <= osc_s2_q;
    end
  end

  assign osc_rise = osc_s2_q && !osc_prev_q;
  assign sec_wr   = wr_at(req, `RTCC_OFS_SEC);
  assign sec_tick = osc_rise && (div_q == DIV_LAST) && !sec_wr;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (sec_wr) begin
      div_q <= '0;
    end else if (osc_rise) begin
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
    end
  end

  // ============================================================
  // time and calendar counters
  rtcc_time_t tm_q;
  logic [7:0] sec_n, min_n, mday_n, mon_n, year_n;
  logic       sec_w, min_w, mday_w, mon_w, year_w;
  logic [7:0] hour_n;
  logic       hour_w;
  logic       min_c, hour_c, day_c, mon_c, year_c;

  rtcc_bcd_step u_sec (
    .cur  (tm_q.sec),
    .lo   (`RTCC_BCD_00),
    .hi   (`RTCC_BCD_59),
    .nxt  (sec_n),
    .wrap (sec_w)
  );
  rtcc_bcd_step u_min (
    .cur  (tm_q.min),
    .lo   (`RTCC_BCD_00),
    .hi   (`RTCC_BCD_59),
    .nxt  (min_n),
    .wrap (min_w)
  );
  rtcc_bcd_step u_mday (
    .cur  (tm_q.mday),
    .lo   (`RTCC_BCD_01),
    .hi   (last_day(tm_q.month, tm_q.year)),
    .nxt  (mday_n),
    .wrap (mday_w)
  );
  rtcc_bcd_step u_mon (
    .cur  (tm_q.month),
    .lo   (`RTCC_BCD_01),
    .hi   (`RTCC_BCD_12),
    .nxt  (mon_n),
    .wrap (mon_w)
  );
  rtcc_bcd_step u_year (
    .cur  (tm_q.year),
    .lo   (`RTCC_BCD_00),
    .hi   (`RTCC_BCD_99),
    .nxt  (year_n),
    .wrap (year_w)
  );

  // hour step: 12-hour runs 12,01..11 then PM 32,21..31
  always_comb begin
    logic [7:0] h;
    h      = {3'b000, tm_q.hour[4:0]};
    hour_w = 1'b0;
    hour_n = tm_q.hour;
    if (mode_24h) begin
      hour_w = (tm_q.hour == `RTCC_BCD_23);
      hour_n = hour_w ? `RTCC_BCD_00 :
               (h[3:0] == 4'h9) ? {tm_q.hour[7:4] + 4'h1, 4'h0} :
               tm_q.hour + 8'h01;
    end else if (h == `RTCC_BCD_12) begin
      hour_n = {2'b00, tm_q.hour[`RTCC_PM_BIT], 5'h01};
    end else if (h == `RTCC_BCD_11) begin
      hour_w = tm_q.hour[`RTCC_PM_BIT];
      hour_n = {2'b00, !tm_q.hour[`RTCC_PM_BIT], 5'h12};
    end else if (h[3:0] == 4'h9) begin
      hour_n = {2'b00, tm_q.hour[`RTCC_PM_BIT], 5'h10};
    end else begin
      hour_n = tm_q.hour + 8'h01;
    end
  end

  assign min_c  = sec_tick && sec_w;
  assign hour_c = min_c && min_w;
  assign day_c  = hour_c && hour_w;
  assign mon_c  = day_c && mday_w;
  assign year_c = mon_c && mon_w;

  // writes take priority over a carry in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tm_q <= '0;
    end else begin
      if (sec_wr) begin
        tm_q.sec <= req.wdata & `RTCC_MSK_SEC;
      end else if (sec_tick) begin
        tm_q.sec <= sec_n;
      end
      if (wr_at(req, `RTCC_OFS_MIN)) begin
        tm_q.min <= req.wdata & `RTCC_MSK_MIN;
      end else if (min_c) begin
        tm_q.min <= min_n;
      end
      if (wr_at(req, `RTCC_OFS_HOUR)) begin
        tm_q.hour <= req.wdata & `RTCC_MSK_HOUR;
      end else if (hour_c) begin
        tm_q.hour <= hour_n;
      end
      if (wr_at(req, `RTCC_OFS_WDAY)) begin
        tm_q.wday <= req.wdata[2:0];
      end else if (day_c) begin
        tm_q.wday <= (tm_q.wday == `RTCC_WDAY_LAST) ? 3'h0 :
                     tm_q.wday + 3'h1;
      end
      if (wr_at(req, `RTCC_OFS_MDAY)) begin
        tm_q.mday <= req.wdata & `RTCC_MSK_MDAY;
      end else if (day_c) begin
        tm_q.mday <= mday_n;
      end
      if (wr_at(req, `RTCC_OFS_MONTH)) begin
        tm_q.month   <= {3'b000, req.wdata[4:0]};
        tm_q.century <= req.wdata[`RTCC_CENT_BIT];
      end else if (mon_c) begin
        tm_q.month <= mon_n;
      end
      if (year_c && !wr_at(req, `RTCC_OFS_MONTH)) begin
        tm_q.century <= !tm_q.century;
      end
      if (wr_at(req, `RTCC_OFS_YEAR)) begin
        tm_q.year <= req.wdata;
      end else if (mon_c && mon_w) begin
        tm_q.year <= year_n;
      end
    end
  end

  // ============================================================
  // periodic interrupt
  rtcc_psel_t psel;
  logic       period_evt;
  logic       level_q;
  logic       periodic_low;
  logic       ctrl2_wr;

  assign psel     = rtcc_psel_t'(periodic_select);
  assign ctrl2_wr = wr_at(req, `RTCC_OFS_CTRL2);

  always_comb begin
    case (psel)
      RTCC_PS_SEC:   period_evt = sec_tick;
      RTCC_PS_MIN:   period_evt = min_c;
      RTCC_PS_HOUR:  period_evt = hour_c;
      RTCC_PS_MONTH: period_evt = mon_c;
      default:       period_evt = 1'b0;
    endcase
  end

  // an event in the clearing cycle survives the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (power_on_flag || !psel[2]) begin
      level_q <= 1'b0;
    end else if (period_evt) begin
      level_q <= 1'b1;
    end else if (ctrl2_wr && !req.wdata[`RTCC_B_PFLAG]) begin
      level_q <= 1'b0;
    end
  end

  always_comb begin
    case (psel)
      RTCC_PS_LOW: periodic_low = !power_on_flag;
      RTCC_PS_2HZ: periodic_low = !power_on_flag &&
                                  ((div_q < DIV_QTR) ||
                                   (div_q >= DIV_HALF &&
                                    div_q < DIV_HALF + DIV_QTR));
      RTCC_PS_1HZ: periodic_low = !power_on_flag && (div_q < DIV_HALF);
      RTCC_PS_OFF: periodic_low = 1'b0;
      default:     periodic_low = level_q;
    endcase
  end

  // ============================================================
  // alarm flags, set after the match settle delay
  logic             wk_flag_q, dy_flag_q;
  logic             wmatch_q, dmatch_q;
  logic [DLY_W-1:0] wcnt_q, dcnt_q;
  logic             wk_flag_vis, dy_flag_vis;
  logic             w_set, d_set;

  assign w_set = (wcnt_q == DLY_W'(1));
  assign d_set = (dcnt_q == DLY_W'(1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wmatch_q <= 1'b0;
      dmatch_q <= 1'b0;
      wcnt_q   <= '0;
      dcnt_q   <= '0;
    end else begin
      wmatch_q <= weekly_alarm_match;
      dmatch_q <= daily_alarm_match;
      if (!weekly_alarm_enable) begin
        wcnt_q <= '0;
      end else if (weekly_alarm_match && !wmatch_q) begin
        wcnt_q <= ALARM_DLY;
      end else if (wcnt_q != '0) begin
        wcnt_q <= wcnt_q - DLY_W'(1);
      end
      if (!daily_alarm_enable) begin
        dcnt_q <= '0;
      end else if (daily_alarm_match && !dmatch_q) begin
        dcnt_q <= ALARM_DLY;
      end else if (dcnt_q != '0) begin
        dcnt_q <= dcnt_q - DLY_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wk_flag_q <= 1'b0;
      dy_flag_q <= 1'b0;
    end else if (power_on_flag) begin
      wk_flag_q <= 1'b0;
      dy_flag_q <= 1'b0;
    end else begin
      if (w_set) begin
        wk_flag_q <= 1'b1;
      end else if (ctrl2_wr && !req.wdata[`RTCC_B_WFLAG]) begin
        wk_flag_q <= 1'b0;
      end
      if (d_set) begin
        dy_flag_q <= 1'b1;
      end else if (ctrl2_wr && !req.wdata[`RTCC_B_DFLAG]) begin
        dy_flag_q <= 1'b0;
      end
    end
  end

  assign wk_flag_vis = wk_flag_q && weekly_alarm_enable;
  assign dy_flag_vis = dy_flag_q && daily_alarm_enable;

  // pin built from the same terms the flags read back
  assign irq_out_n = !(periodic_low || wk_flag_vis || dy_flag_vis);

  // ============================================================
  // register read port, one cycle latency
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (req.rd) begin
      if (req.addr == `RTCC_OFS_SEC) begin
        rdata <= tm_q.sec;
      end else if (req.addr == `RTCC_OFS_MIN) begin
        rdata <= tm_q.min;
      end else if (req.addr == `RTCC_OFS_HOUR) begin
        rdata <= tm_q.hour;
      end else if (req.addr == `RTCC_OFS_WDAY) begin
        rdata <= {5'b00000, tm_q.wday};
      end else if (req.addr == `RTCC_OFS_MDAY) begin
        rdata <= tm_q.mday;
      end else if (req.addr == `RTCC_OFS_MONTH) begin
        rdata <= {tm_q.century, 2'b00, tm_q.month[4:0]};
      end else if (req.addr == `RTCC_OFS_YEAR) begin
        rdata <= tm_q.year;
      end else if (req.addr == `RTCC_OFS_CTRL2) begin
        rdata <= {3'b000, power_on_flag, 1'b0, periodic_low,
                  wk_flag_vis, dy_flag_vis};
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // ============================================================
  // checks
  chk_pflag_pin: assert property (periodic_low |-> !irq_out_n)
    else $error("periodic low, pin high");
  chk_pflag_clear: assert property (
    psel[2] && ctrl2_wr && !req.wdata[`RTCC_B_PFLAG] && !period_evt
    |=> !level_q) else $error("periodic flag not cleared");
  chk_alarm_delay: assert property (
    $rose(wk_flag_q) |-> $past(wcnt_q) == DLY_W'(1))
    else $error("weekly flag set without delay");
  chk_alarm_clear: assert property (
    ctrl2_wr && !req.wdata[`RTCC_B_DFLAG] && !d_set |=> !dy_flag_q)
    else $error("daily flag not cleared");
  chk_alarm_mask: assert property (
    req.rd && req.addr == `RTCC_OFS_CTRL2 && !weekly_alarm_enable
    |=> !rdata[`RTCC_B_WFLAG]) else $error("masked weekly flag read");
  chk_pin_agree: assert property (
    (wk_flag_vis || dy_flag_vis) |-> !irq_out_n)
    else $error("alarm flag without pin");
  chk_sec_wrap: assert property (
    sec_tick && tm_q.sec == `RTCC_BCD_59 && !req.wr
    |=> tm_q.sec == `RTCC_BCD_00 && tm_q.min != $past(tm_q.min))
    else $error("seconds carry wrong");
  chk_div_clear: assert property (sec_wr |=> div_q == '0)
    else $error("divider not cleared");
  chk_wday_wrap: assert property (
    day_c && tm_q.wday == 3'h6 && !req.wr |=> tm_q.wday == 3'h0)
    else $error("weekday wrap wrong");
  chk_cent_flip: assert property (
    year_c && !req.wr |=> tm_q.century != $past(tm_q.century))
    else $error("century did not toggle");
  cov_min_carry: cover property (@(posedge core_clk) min_c);
  cov_alarm_set: cover property (@(posedge core_clk) $rose(wk_flag_vis));
  cov_level_irq: cover property (@(posedge core_clk) $rose(level_q));

endmodule // rtcc_core

`default_nettype wire

// File: bench/rtcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// host side of the register port
module rtcc_host_model (
  input  wire logic                core_clk,
  output var  rtcc_pkg::rtcc_req_t req,
  input  wire logic          [7:0] rdata
);
  import rtcc_pkg::*;

  initial req = '{wr: 1'b0, rd: 1'b0, addr: 4'h7, wdata: 8'h00};

  // released fields flip so a stale value never looks held
  task automatic drop();
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~req.addr;
    req.wdata = ~req.wdata;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge core_clk);
    drop();
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge core_clk);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge core_clk);
    drop();
    @(negedge core_clk);
    d = rdata;
  endtask
endmodule // rtcc_host_model

`default_nettype wire

// File: bench/rtcc_time_calendar_counters_tb.sv
`include "rtcc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rtcc_time_calendar_counters_tb;
  import rtcc_pkg::*;

  logic        core_clk, rst_n, osc_clk, mode_24h, pwr_on;
  logic        wk_en, dy_en, wk_m, dy_m, irq_out_n;
  logic [2:0]  psel;
  logic [7:0]  rdata, v;
  rtcc_req_t   req;
  int          n_mismatch, cmp_count, cyc;
  logic [31:0] rs = 32'd18255;

  rtcc_host_model u_host (.core_clk(core_clk), .req(req), .rdata(rdata));

  rtcc_core #(.OSC_PER_SEC(8)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .osc_clk(osc_clk), .req(req),
    .rdata(rdata), .periodic_select(psel), .mode_24h(mode_24h),
    .weekly_alarm_enable(wk_en), .daily_alarm_enable(dy_en),
    .weekly_alarm_match(wk_m), .daily_alarm_match(dy_m),
    .power_on_flag(pwr_on), .irq_out_n(irq_out_n));

  // ============================================================
  // clocks: oscillator runs free, unrelated in phase
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    osc_clk = 1'b0;
    #3;
    forever #62.5 osc_clk = ~osc_clk;
  end

  // ============================================================
  // helpers
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  function automatic logic [7:0] i2b(input int i);
    return 8'((i / 10) * 16 + i % 10);
  endfunction
  function automatic int b2i(input logic [7:0] b);
    return int'(b[7:4]) * 10 + int'(b[3:0]);
  endfunction
  function automatic logic [7:0] last_day(input logic [7:0] m, y);
    case (b2i(m))
      2:          return (b2i(y) % 4 == 0) ? 8'h29 : 8'h28;
      4, 6, 9, 11: return 8'h30;
      default:    return 8'h31;
    endcase
  endfunction
  function automatic logic [7:0] mask(input int a);
    case (a)
      0, 1:    return `RTCC_MSK_SEC;
      2:       return `RTCC_MSK_HOUR;
      3:       return `RTCC_MSK_WDAY;
      4:       return `RTCC_MSK_MDAY;
      5:       return `RTCC_MSK_MONTH;
      6:       return `RTCC_MSK_YEAR;
      default: return 8'h00;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    u_host.rd(a, v);
    check(v, e);
  endtask
  task automatic cwait(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // seconds last: its write restarts the divider, tick ~100 cycles on
  task automatic set_time(input logic [7:0] y, mo, md, wd, h);
    u_host.wr(4'h6, y);
    u_host.wr(4'h5, mo);
    u_host.wr(4'h4, md);
    u_host.wr(4'h3, wd);
    u_host.wr(4'h2, h);
    u_host.wr(4'h1, 8'h59);
    u_host.wr(4'h0, 8'h59);
    cwait(130);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ============================================================
  // main sequence
  initial begin
    logic [7:0] y, mo, e, bm;
    rst_n = 1'b0;
    psel = 3'h0;
    mode_24h = 1'b1;
    pwr_on = 1'b0;
    wk_en = 1'b0;
    dy_en = 1'b0;
    wk_m = 1'b0;
    dy_m = 1'b0;
    cwait(20);
    rst_n = 1'b1;
    for (int a = 0; a < 8; a++) rchk(a[3:0], 8'h00);
    rchk(`RTCC_OFS_CTRL2, 8'h00);
    for (int a = 0; a < 8; a++) begin
      e = rnd();
      u_host.wr(a[3:0], e);
      rchk(a[3:0], e & mask(a));
    end
    $display("test reset and masks done");
    // host keeps to valid times and weekday codes from here
    set_time(8'h99, 8'h12, 8'h31, 8'h06, 8'h23);
    rchk(4'h0, 8'h00);
    rchk(4'h1, 8'h00);
    rchk(4'h2, 8'h00);
    rchk(4'h3, 8'h00);
    rchk(4'h4, 8'h01);
    rchk(4'h5, 8'h81);
    rchk(4'h6, 8'h00);
    for (int k = 0; k < 9; k++) begin
      y = (k == 0) ? 8'h04 : (k == 1) ? 8'h00 : (k == 2) ? 8'h01 :
          i2b(int'(rnd()) % 99);
      mo = (k < 3) ? 8'h02 : (k == 3) ? 8'h04 : i2b(int'(rnd()) % 12 + 1);
      // hour and month level modes both see this carry
      psel = k[0] ? 3'h7 : 3'h6;
      u_host.wr(`RTCC_OFS_CTRL2, 8'h00);
      set_time(y, mo, last_day(mo, y), 8'h00, 8'h23);
      rchk(4'h4, 8'h01);
      rchk(4'h5, (mo == 8'h12) ? 8'h01 : i2b(b2i(mo) + 1));
      rchk(4'h6, (mo == 8'h12) ? i2b(b2i(y) + 1) : y);
      check({7'h00, irq_out_n}, 8'h00);
    end
    psel = 3'h0;
    $display("test calendar carries done");
    mode_24h = 1'b0;
    set_time(8'h20, 8'h05, 8'h10, 8'h02, 8'h31);
    rchk(4'h2, 8'h12);
    rchk(4'h4, 8'h11);
    rchk(4'h3, 8'h03);
    set_time(8'h20, 8'h05, 8'h10, 8'h02, 8'h11);
    rchk(4'h2, 8'h32);
    rchk(4'h4, 8'h10);
    mode_24h = 1'b1;
    u_host.wr(4'h0, 8'h10);
    cwait(60);
    u_host.wr(4'h0, 8'h20);
    cwait(80);
    rchk(4'h0, 8'h20);
    cwait(60);
    rchk(4'h0, 8'h21);
    $display("test 12h and divider done");
    psel = 3'h4;
    u_host.wr(`RTCC_OFS_CTRL2, 8'h00);
    u_host.wr(4'h0, 8'h00);
    cwait(130);
    check({7'h00, irq_out_n}, 8'h00);
    rchk(`RTCC_OFS_CTRL2, 8'h04);
    u_host.wr(`RTCC_OFS_CTRL2, 8'h04);
    rchk(`RTCC_OFS_CTRL2, 8'h04);
    u_host.wr(`RTCC_OFS_CTRL2, 8'h00);
    rchk(`RTCC_OFS_CTRL2, 8'h00);
    check({7'h00, irq_out_n}, 8'h01);
    cwait(100);
    check({7'h00, irq_out_n}, 8'h00);
    psel = 3'h5;
    u_host.wr(`RTCC_OFS_CTRL2, 8'h00);
    u_host.wr(4'h0, 8'h58);
    cwait(130);
    check({7'h00, irq_out_n}, 8'h01);
    rchk(`RTCC_OFS_CTRL2, 8'h00);
    cwait(110);
    check({7'h00, irq_out_n}, 8'h00);
    rchk(`RTCC_OFS_CTRL2, 8'h04);
    pwr_on = 1'b1;
    cwait(2);
    rchk(`RTCC_OFS_CTRL2, 8'h10);
    check({7'h00, irq_out_n}, 8'h01);
    pwr_on = 1'b0;
    psel = 3'h1;
    cwait(1);
    check({7'h00, irq_out_n}, 8'h00);
    rchk(`RTCC_OFS_CTRL2, 8'h04);
    // pulse modes: low in the first half (1 Hz) or the first quarter of each half (2 Hz)
    psel = 3'h3;
    u_host.wr(4'h0, 8'h00);
    cwait(1);
    check({7'h00, irq_out_n}, 8'h00);
    cwait(28);
    psel = 3'h2;
    cwait(1);
    check({7'h00, irq_out_n}, 8'h01);
    cwait(30);
    check({7'h00, irq_out_n}, 8'h00);
    psel = 3'h3;
    cwait(1);
    check({7'h00, irq_out_n}, 8'h01);
    psel = 3'h0;
    $display("test periodic done");
    for (int i = 0; i < 2; i++) begin
      bm = (i == 0) ? 8'h02 : 8'h01;
      wk_en = (i == 0);
      dy_en = (i == 1);
      for (int r = 0; r < 2; r++) begin
        cwait(2);
        wk_m = (i == 0);
        dy_m = (i == 1);
        cwait(3090);
        rchk(`RTCC_OFS_CTRL2, 8'h00);
        check({7'h00, irq_out_n}, 8'h01);
        cwait(10);
        rchk(`RTCC_OFS_CTRL2, bm);
        check({7'h00, irq_out_n}, 8'h00);
        wk_m = 1'b0;
        dy_m = 1'b0;
        if (r == 0) begin
          u_host.wr(`RTCC_OFS_CTRL2, bm);
          rchk(`RTCC_OFS_CTRL2, bm);
          u_host.wr(`RTCC_OFS_CTRL2, 8'h00);
          rchk(`RTCC_OFS_CTRL2, 8'h00);
          check({7'h00, irq_out_n}, 8'h01);
        end
      end
      wk_en = 1'b0;
      dy_en = 1'b0;
      rchk(`RTCC_OFS_CTRL2, 8'h00);
      check({7'h00, irq_out_n}, 8'h01);
    end
    $display("test alarms done");
    tally_and_finish();
  end
endmodule // rtcc_time_calendar_counters_tb

`default_nettype wire
